// ### i2c_multimaster_ctrl_bench.sv
// bench: register, slave, master and arbitration runs of the bus controller
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module i2c_multimaster_ctrl_bench;
    import i2cm_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [AW-1:0] addr = '0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, got, own, b;
    logic scl_out, scl_oe, sda_out, sda_oe, bus_irq, scl, sda, ack;
    int err_total = 0;
    int checks_done = 0;
    int irqs = 0;
    int n0;
    logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'hF1, 8'hF6};
    int wtab [8] = '{26, 46, 92, 37, 16, 0, 32, 13};
    always #10 mclk = ~mclk;
    always @(posedge mclk) if (bus_irq === 1'b1) irqs <= irqs + 1;
    i2cm_ctrl u_dut (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .bus_irq(bus_irq));
    i2cm_peer u_peer (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    task automatic final_report();
        if (err_total == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // a write straight after a write lets one edge pass so wr is never set twice at once
    task automatic wreg(input logic [AW-1:0] a, input logic [7:0] d);
        if (wr === 1'b1) @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [AW-1:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        got = rdata;
    endtask
    task automatic wirq(input int c);
        for (int i = 0; i < 40000 && irqs <= c; i++)
            @(posedge mclk);
        if (irqs <= c) begin
            err_total++;
            final_report();
        end
    endtask
    task automatic slave(input logic [7:0] a, input logic [7:0] c);
        n0 = irqs;
        u_peer.go();
        fork
            begin
                u_peer.put(a, ack);
                u_peer.halt();
            end
            begin
                wirq(n0);
                rreg(A_STAT);
                wreg(A_CTRL, c);
            end
        join
        repeat (8) @(posedge mclk);
    endtask
    initial begin
        #1900000;
        err_total++;
        final_report();
    end
    initial begin
        n0 = $urandom(57);
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        for (int a = 0; a < 8; a++) begin
            rreg(a[AW-1:0]);
            `CHK("reset value", RST_BYTE, got)
        end
        own = {7'($urandom_range(119, 8)), 1'b0};
        wreg(A_OWN, own);
        rreg(A_OWN);
        b = 8'($urandom());
        wreg(3'h6, b);
        rreg(3'h6);
        `CHK("unmapped", 8'h00, got)
        wreg(A_CTRL, 8'hBC);
        rreg(A_CTRL);
        `CHK("control", 8'hAC, got)
        wreg(A_CTRL, 8'h00);
        @(posedge mclk);
        rreg(A_STAT);
        wreg(A_CLK, 8'h08);
        wreg(A_CTRL, 8'hA0);
        n0 = irqs;
        wreg(A_CTRL, 8'hA1);
        wirq(n0);
        wreg(A_CTRL, 8'hAC);
        n0 = irqs;
        u_peer.go();
        u_peer.put(own ^ 8'h02, ack);
        `CHK("foreign ack", 1'b1, ack)
        `CHK("foreign irq", n0, irqs)
        @(posedge mclk);
        wreg(A_CTRL, 8'hAE);
        u_peer.halt();
        repeat (8) @(posedge mclk);
        `CHK("stop irq", n0 + 1, irqs)
        repeat (200) @(posedge mclk);
        rreg(A_STAT);
        `CHK("reserved start", 1'b1, got[S_MST])
        n0 = irqs;
        wreg(A_CTRL, 8'hAD);
        wirq(n0);
        slave(own, 8'hBC);
        `CHK("match flags", 2'b01, got[S_EXC:S_COI])
        `CHK("match ack", 1'b0, ack)
        foreach (codes[i]) begin
            slave(codes[i], 8'hEC);
            `CHK("ext flag", 1'b1, got[S_EXC])
            `CHK("ext ack", 1'b1, ack)
            `CHK("ext irqs", n0 + 2, irqs)
        end
        rreg(A_OWN);
        `CHK("own kept", own, got)
        for (int s = 0; s < 8; s++) begin
            if (s == 5) continue;
            wreg(A_CLK, {4'h0, s[2], 1'b0, s[1:0]});
            wreg(A_CTRL, 8'hAE);
            repeat (wtab[s]) @(posedge mclk);
            rreg(A_STAT);
            `CHK("master state", 1'b1, got[S_MST])
            repeat ((s[2] ? 126 : 500) << s[1:0]) @(posedge mclk);
            n0 = irqs;
            wreg(A_CTRL, 8'hAD);
            wirq(n0);
            rreg(A_STAT);
            `CHK("master off", 1'b0, got[S_MST])
        end
        wreg(A_CTRL, 8'hAE);
        repeat (1100) @(posedge mclk);
        b = own ^ 8'h84;
        n0 = irqs;
        wreg(A_SHIFT, b);
        wirq(n0);
        rreg(A_SHIFT);
        `CHK("line capture", b, got)
        n0 = irqs;
        wreg(A_CTRL, 8'hAD);
        wirq(n0);
        wreg(A_CTRL, 8'hAE);
        repeat (1100) @(posedge mclk);
        u_peer.p_sda <= 1'b1;
        wreg(A_SHIFT, b | 8'h80);
        repeat (1100) @(posedge mclk);
        rreg(A_STAT);
        `CHK("arb lost", 1'b1, got[S_ALD])
        `CHK("lines free", 2'b00, {scl_oe, sda_oe})
        n0 = irqs;
        u_peer.p_sda <= 1'b0;
        repeat (8) @(posedge mclk);
        `CHK("loss stop irq", n0 + 1, irqs)
        final_report();
    end
endmodule
bind i2cm_ctrl i2cm_chk u_chk (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .bus_irq(bus_irq));

// ### i2cm_assertions.sv
// checker: port-level properties of the two-wire bus controller
`timescale 1ns/1ns
module i2cm_chk (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [i2cm_pkg::AW-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic bus_irq
);
    import i2cm_pkg::*;
    // ------
    // properties
    // ------
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_wctl;
        wr && addr == A_CTRL;
    endsequence
    sequence s_rctl;
        rd && addr == A_CTRL;
    endsequence
    chk_open_drain: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    chk_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its slot");
    chk_irq_pulse: assert property (bus_irq |=> !bus_irq)
        else $error("irq longer than one cycle");
    chk_off_release: assert property (wr && addr == A_CTRL && !wdata[C_EN] |-> ##2 !scl_oe && !sda_oe)
        else $error("lines held while disabled");
    chk_unmapped_zero: assert property (rd && addr > A_CLK |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_trigger_zero: assert property (s_rctl |=> (rdata & ~CTRL_KEEP) == 8'h00)
        else $error("trigger bit read back");
    chk_ctrl_back: assert property (s_wctl ##1 s_rctl |=> rdata == ($past(wdata, 2) & CTRL_KEEP))
        else $error("control readback wrong");
    chk_own_keep: assert property (wr && addr == A_OWN ##1 rd && addr == A_OWN |=> rdata == $past(wdata, 2))
        else $error("own address readback wrong");
    chk_off_status: assert property (wr && addr == A_CTRL && !wdata[C_EN] ##2 rd && addr == A_STAT |=> rdata[7:3] == 5'h00)
        else $error("status kept while disabled");
endmodule

// ### i2cm_ctrl.sv
// two-wire multi-master bus controller: registers, bus monitor, byte engine, clock generator
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module i2cm_ctrl (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [i2cm_pkg::AW-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic bus_irq
);
    import i2cm_pkg::*;

    logic [7:0] shift, own, ctrl, clk_sel;
    logic [1:0] scl_sy, sda_sy;
    logic scl_p, sda_p;
    logic master, resv, trc, ext_f, coi_f, ald_f, ackd_f, std_f, spd_f;
    logic slave_on, addr_ph, xfer_on, al_pend, hold, sda_dat, rwb;
    logic [3:0] bitcnt;
    logic [11:0] tcnt;
    logic g_scl, g_sda;
    i2cm_gen_t gs;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // nibble 0000 covers general call, start byte, alternate bus and reserved
    // codes; 1111 covers the 10-bit prefix
    function automatic logic is_ext(input logic [7:0] b);
        return (b[7:4] == EXT_LO) || (b[7:4] == EXT_HI);
    endfunction

    function automatic logic [11:0] half_of(input logic [7:0] k);
        return (k[K_SMC] ? HALF_FAST : HALF_STD) << k[K_CL1:K_CL0];
    endfunction

    wire scl_s = scl_sy[1];
    wire sda_s = sda_sy[1];
    wire en = ctrl[C_EN];
    wire spie = ctrl[C_SPIE];
    wire wtim = ctrl[C_WTIM];
    wire acke = ctrl[C_ACKE];
    wire [11:0] half = half_of(clk_sel);
    wire wr_shift = wr && (addr == A_SHIFT);
    wire wr_ctrl = wr && (addr == A_CTRL) && en;
    wire do_lrel = wr_ctrl && wdata[C_LREL];
    wire do_wrel = wr_ctrl && wdata[C_WREL];
    wire do_stt = wr_ctrl && wdata[C_STT];
    wire do_spt = wr_ctrl && wdata[C_SPT];
    wire rel = hold && (do_wrel || wr_shift || do_stt || do_spt);
    wire tick = (tcnt == 12'h000);

    // ------------------------------------------------------------
    // bus conditions seen on the synchronised lines
    // ------------------------------------------------------------
    wire sta_det = scl_s && scl_p && sda_p && !sda_s;
    wire sto_det = scl_s && scl_p && !sda_p && sda_s;
    wire scl_rise = scl_s && !scl_p;
    wire scl_fall = !scl_s && scl_p;
    wire fall8 = xfer_on && scl_fall && (bitcnt == BIT8);
    wire fall9 = xfer_on && scl_fall && (bitcnt == BIT9);
    wire a_slv = addr_ph && !master;
    wire e_now = is_ext(shift);
    wire m_now = (shift[7:1] == own[7:1]);

    // interrupt points; a non-matching slave stays silent
    wire i8 = a_slv ? e_now : ((master || slave_on) && !wtim);
    wire i9 = master ? (addr_ph || wtim)
        : (slave_on && (addr_ph ? (coi_f && !ext_f) : wtim));
    wire al8 = al_pend && !wtim && (addr_ph ? e_now : ext_f);
    wire trc9 = addr_ph ? (master ? !rwb : (slave_on && rwb)) : trc;

    // a released data bit that reads back low means another master won
    wire al_data = xfer_on && scl_rise && master && trc && !sda_dat && !sda_s
        && (bitcnt < BIT8);
    wire al_stop = sto_det && master && (gs != G_PCHK);
    wire al_gen = tick && ((gs == G_RHI && scl_s && !sda_s)
        || (gs == G_STA && !scl_s)
        || (gs == G_PCHK && master && !sto_det));
    wire al_ev = al_data || al_stop || al_gen;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_sy <= {scl_sy[0], scl_in};
            sda_sy <= {sda_sy[0], sda_in};
            scl_p <= scl_sy[1];
            sda_p <= sda_sy[1];
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // own_address_reg is written by software only; decoding never alters it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= RST_BYTE;
            own <= RST_BYTE;
            clk_sel <= RST_BYTE;
        end else if (wr) begin
            if (addr == A_CTRL) begin
                ctrl <= wdata & CTRL_KEEP;
            end
            if (addr == A_OWN) begin
                own <= wdata;
            end
            if (addr == A_CLK) begin
                clk_sel <= wdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= RST_BYTE;
        end else if (rd) begin
            case (addr)
                A_SHIFT: rdata <= shift;
                A_CTRL: rdata <= ctrl;
                A_STAT: rdata <= {master, ald_f, ext_f, coi_f, trc, ackd_f, std_f, spd_f};
                A_OWN: rdata <= own;
                A_CLK: rdata <= clk_sel;
                default: rdata <= RST_BYTE;
            endcase
        end else begin
            rdata <= RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    // the line is captured even while sending, so software can compare
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            shift <= RST_BYTE;
        end else if (wr_shift) begin
            shift <= wdata;
        end else if (en && xfer_on && scl_rise && bitcnt < BIT8) begin
            shift <= {shift[6:0], sda_s};
        end
    end

    // ------------------------------------------------------------
    // byte engine: bit count, decode, ack, wait
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            xfer_on <= 1'b0;
            addr_ph <= 1'b0;
            slave_on <= 1'b0;
            bitcnt <= BIT0;
            hold <= 1'b0;
            sda_dat <= 1'b0;
            trc <= 1'b0;
            ext_f <= 1'b0;
            coi_f <= 1'b0;
            ackd_f <= 1'b0;
            rwb <= 1'b0;
        end else if (!en) begin
            xfer_on <= 1'b0;
            addr_ph <= 1'b0;
            slave_on <= 1'b0;
            bitcnt <= BIT0;
            hold <= 1'b0;
            sda_dat <= 1'b0;
            trc <= 1'b0;
            ext_f <= 1'b0;
            coi_f <= 1'b0;
            ackd_f <= 1'b0;
            rwb <= 1'b0;
        end else begin
            if (sta_det) begin
                xfer_on <= 1'b1;
                addr_ph <= 1'b1;
                bitcnt <= BIT0;
                slave_on <= 1'b0;
                ext_f <= 1'b0;
                coi_f <= 1'b0;
                trc <= master;
                sda_dat <= 1'b0;
            end else if (sto_det) begin
                xfer_on <= 1'b0;
                addr_ph <= 1'b0;
                slave_on <= 1'b0;
                hold <= 1'b0;
                sda_dat <= 1'b0;
                trc <= 1'b0;
            end else if (do_lrel) begin
                slave_on <= 1'b0;
                addr_ph <= 1'b0;
                hold <= 1'b0;
                sda_dat <= 1'b0;
                trc <= 1'b0;
                ext_f <= 1'b0;
                coi_f <= 1'b0;
            end else if (rel) begin
                hold <= 1'b0;
                if (do_stt || do_spt) begin
                    sda_dat <= 1'b0;
                end else if (bitcnt == BIT8) begin
                    // ack level is set on the same edge that ends the wait
                    sda_dat <= !trc && (master || slave_on) && acke;
                end else if (wr_shift) begin
                    sda_dat <= trc && !wdata[7];
                end
            end else if (xfer_on && scl_rise) begin
                bitcnt <= bitcnt + BIT1;
                if (bitcnt == BIT8) begin
                    ackd_f <= !sda_s;
                end
            end else if (xfer_on && scl_fall) begin
                case (bitcnt)
                    BIT8: begin
                        rwb <= shift[0];
                        if (a_slv) begin
                            ext_f <= e_now;
                            coi_f <= m_now;
                            slave_on <= e_now || m_now;
                            sda_dat <= m_now || (e_now && acke);
                        end else begin
                            sda_dat <= !trc && (master || slave_on) && acke;
                        end
                        hold <= i8;
                    end
                    BIT9: begin
                        bitcnt <= BIT0;
                        addr_ph <= 1'b0;
                        hold <= i9;
                        trc <= trc9;
                        sda_dat <= trc9 && !shift[7];
                    end
                    default: begin
                        sda_dat <= trc && !shift[7];
                        if (bitcnt == BIT0 && addr_ph && master) begin
                            hold <= 1'b1;
                        end
                    end
                endcase
            end
            if (al_ev) begin
                trc <= 1'b0;
                sda_dat <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // status flags and interrupt pulse
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            std_f <= 1'b0;
            spd_f <= 1'b0;
            ald_f <= 1'b0;
            al_pend <= 1'b0;
            bus_irq <= 1'b0;
        end else if (!en) begin
            std_f <= 1'b0;
            spd_f <= 1'b0;
            ald_f <= 1'b0;
            al_pend <= 1'b0;
            bus_irq <= 1'b0;
        end else begin
            if (sta_det) begin
                std_f <= 1'b1;
                spd_f <= 1'b0;
            end
            if (sto_det) begin
                std_f <= 1'b0;
                spd_f <= 1'b1;
            end
            bus_irq <= (fall8 && (i8 || al8)) || (fall9 && (i9 || al_pend))
                || (sto_det && spie);
            if (sto_det || (fall8 && al8) || fall9) begin
                al_pend <= 1'b0;
            end
            // a new loss outranks the clear in the same cycle, except when a stop is detected
            if (al_ev && !sto_det) begin
                al_pend <= 1'b1;
            end
            if (rd && addr == A_STAT) begin
                ald_f <= 1'b0;
            end
            if (al_ev) begin
                ald_f <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // master clock and condition generator
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gs <= G_IDLE;
            master <= 1'b0;
            resv <= 1'b0;
            g_scl <= 1'b0;
            g_sda <= 1'b0;
            tcnt <= 12'h000;
        end else if (!en || al_ev) begin
            gs <= G_IDLE;
            master <= 1'b0;
            g_scl <= 1'b0;
            g_sda <= 1'b0;
            if (!en) begin
                resv <= 1'b0;
            end
        end else begin
            if (!tick) begin
                tcnt <= tcnt - CNT_ONE;
            end
            case (gs)
                G_IDLE: begin
                    if (do_spt && !master) begin
                        gs <= G_PLO;
                        g_scl <= 1'b1;
                        g_sda <= 1'b1;
                        tcnt <= half;
                    end else if ((do_stt && spd_f) || (resv && sto_det)) begin
                        gs <= G_STA;
                        g_sda <= 1'b1;
                        master <= 1'b1;
                        resv <= 1'b0;
                        tcnt <= half;
                    end else if (do_stt && std_f) begin
                        resv <= 1'b1;
                    end
                end
                G_RLO: begin
                    if (tick) begin
                        gs <= G_RHI;
                        g_scl <= 1'b0;
                        tcnt <= half;
                    end
                end
                G_RHI: begin
                    if (!scl_s) begin
                        tcnt <= half;
                    end else if (tick) begin
                        gs <= G_STA;
                        g_sda <= 1'b1;
                        tcnt <= half;
                    end
                end
                G_STA: begin
                    if (tick) begin
                        gs <= G_LOW;
                        g_scl <= 1'b1;
                        tcnt <= half;
                    end
                end
                G_LOW: begin
                    // the start is complete once the clock is low; data bits come from sda_dat
                    g_sda <= 1'b0;
                    if (hold) begin
                        gs <= G_WAIT;
                    end else if (tick) begin
                        gs <= G_HIGH;
                        g_scl <= 1'b0;
                        tcnt <= half;
                    end
                end
                G_HIGH: begin
                    // an early fall from a faster master restarts our low phase
                    if (scl_fall || (scl_s && tick)) begin
                        gs <= G_LOW;
                        g_scl <= 1'b1;
                        tcnt <= half;
                    end else if (!scl_s) begin
                        tcnt <= half;
                    end
                end
                G_WAIT: begin
                    if (do_spt) begin
                        gs <= G_PLO;
                        g_sda <= 1'b1;
                        tcnt <= half;
                    end else if (do_stt) begin
                        gs <= G_RLO;
                        tcnt <= half;
                    end else if (!hold) begin
                        gs <= G_LOW;
                        tcnt <= half;
                    end
                end
                G_PLO: begin
                    if (tick) begin
                        gs <= G_PHI;
                        g_scl <= 1'b0;
                        tcnt <= half;
                    end
                end
                G_PHI: begin
                    if (!scl_s) begin
                        tcnt <= half;
                    end else if (tick) begin
                        gs <= G_PCHK;
                        g_sda <= 1'b0;
                        tcnt <= half;
                    end
                end
                G_PCHK: begin
                    if (sto_det) begin
                        gs <= G_IDLE;
                        master <= 1'b0;
                    end
                end
                default: gs <= G_IDLE;
            endcase
        end
    end

    // open-drain lines: the level driven is always low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = g_scl || hold;
    assign sda_oe = g_sda || sda_dat;
endmodule

// ### i2cm_peer.sv
// far-side model: another master on the pulled-up clock and data lines
`timescale 1ns/1ns
module i2cm_peer (
    input wire logic scl_oe,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic p_scl = 1'b0;
    logic p_sda = 1'b0;
    // pull-ups: a line that nobody pulls reads high
    assign scl = !(scl_oe || p_scl);
    assign sda = !(sda_oe || p_sda);
    // bounded, so a clock held low for good cannot hang the run
    task automatic hi();
        p_scl = 1'b0;
        for (int i = 0; i < 4000 && !scl; i++)
            #20;
        #80;
    endtask
    task automatic go();
        p_sda = 1'b1;
        #80;
        p_scl = 1'b1;
    endtask
    task automatic halt();
        p_sda = 1'b1;
        #80;
        hi();
        p_sda = 1'b0;
        #80;
    endtask
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            p_sda = !b[i];
            #80;
            hi();
            p_scl = 1'b1;
        end
        p_sda = 1'b0;
        #80;
        hi();
        ack = sda;
        p_scl = 1'b1;
    endtask
endmodule

// ### i2cm_pkg.sv
// package: register map, field positions, timing and states of the two-wire bus controller
package i2cm_pkg;
    // ------------------------------------------------------------
    // register map (word index on the plain register port)
    // ------------------------------------------------------------
    localparam int AW = 3;
    localparam logic [2:0] A_SHIFT = 3'h0;
    localparam logic [2:0] A_CTRL = 3'h1;
    localparam logic [2:0] A_STAT = 3'h2;
    localparam logic [2:0] A_OWN = 3'h3;
    localparam logic [2:0] A_CLK = 3'h4;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ------------------------------------------------------------
    // bus_ctrl_reg fields
    // ------------------------------------------------------------
    localparam int C_EN = 7;
    localparam int C_LREL = 6;
    localparam int C_SPIE = 5;
    localparam int C_WREL = 4;
    localparam int C_WTIM = 3;
    localparam int C_ACKE = 2;
    localparam int C_STT = 1;
    localparam int C_SPT = 0;
    // only these bits are stored, the others act on write and read as zero
    localparam logic [7:0] CTRL_KEEP = 8'hAC;

    // ------------------------------------------------------------
    // bus_status_reg and clk_select_reg fields
    // ------------------------------------------------------------
    localparam int S_MST = 7;
    localparam int S_ALD = 6;
    localparam int S_EXC = 5;
    localparam int S_COI = 4;
    localparam int S_TRC = 3;
    localparam int S_ACKD = 2;
    localparam int S_STD = 1;
    localparam int S_SPD = 0;
    localparam int K_SMC = 3;
    localparam int K_CL1 = 1;
    localparam int K_CL0 = 0;

    // ------------------------------------------------------------
    // address decode and bit counting
    // ------------------------------------------------------------
    localparam logic [3:0] EXT_LO = 4'h0;
    localparam logic [3:0] EXT_HI = 4'hF;
    localparam logic [3:0] BIT0 = 4'h0;
    localparam logic [3:0] BIT1 = 4'h1;
    localparam logic [3:0] BIT8 = 4'h8;
    localparam logic [3:0] BIT9 = 4'h9;

    // half serial clock period in mclk cycles, shifted left by the rate bits
    localparam logic [11:0] HALF_STD = 12'h0FA;
    localparam logic [11:0] HALF_FAST = 12'h03F;
    localparam logic [11:0] CNT_ONE = 12'h001;

    typedef enum logic [9:0] {
        G_IDLE = 10'h001,
        G_RLO = 10'h002,
        G_RHI = 10'h004,
        G_STA = 10'h008,
        G_LOW = 10'h010,
        G_HIGH = 10'h020,
        G_WAIT = 10'h040,
        G_PLO = 10'h080,
        G_PHI = 10'h100,
        G_PCHK = 10'h200
    } i2cm_gen_t;
endpackage
